// ### hw/dms_defs.svh
`ifndef DMS_DEFS_SVH
`define DMS_DEFS_SVH

`define DMS_DATA_W 16
`define DMS_DEPTH 16
`define DMS_ADDR_W 4
// Strobe to request update bound, ns, and cycles at 50 MHz
`define DMS_CLK_NS 20
`define DMS_REQ_DELAY_NS 36
`define DMS_REQ_DELAY_CYC ((`DMS_REQ_DELAY_NS) / (`DMS_CLK_NS))
`define DMS_STROBE_MIN_NS 30
`define DMS_STROBE_MIN_CYC \
    (((`DMS_STROBE_MIN_NS) + (`DMS_CLK_NS) - 1) / (`DMS_CLK_NS))
`define DMS_TX_WORDS_RST 4'h0

`endif

// ### hw/dms_pkg.sv
package dms_pkg;
    typedef enum logic [1:0] {
        DMS_IDLE = 2'b00,
        DMS_STROBE = 2'b01,
        DMS_RECOVER = 2'b11
    } dms_state_t;

    typedef enum logic [1:0] {
        DMS_DIR_NONE = 2'h0,
        DMS_DIR_WRITE = 2'h1,
        DMS_DIR_READ = 2'h2
    } dms_dir_t;
endpackage : dms_pkg

// ### hw/dms_if.sv
`timescale 1ns/1ps
`include "dms_defs.svh"
interface dms_if;
    logic dmaAckN;
    logic rdN;
    logic wrN;
    logic [`DMS_DATA_W-1:0] dataToDev;
    logic [`DMS_DATA_W-1:0] dataFromDev;
    logic dataFromDevOe;
    logic dmaTxRequest;
    logic dmaRxRequest;

    modport dev (
        input dmaAckN, rdN, wrN, dataToDev,
        output dataFromDev, dataFromDevOe, dmaTxRequest, dmaRxRequest
    );
    modport ctl (
        output dmaAckN, rdN, wrN, dataToDev,
        input dataFromDev, dataFromDevOe, dmaTxRequest, dmaRxRequest
    );
endinterface : dms_if

// ### hw/dms_device.sv
// Functional notes
// - Normal mode: rdN high, wrN low writes
// - Normal mode: rdN low, wrN high reads
// - Fly-by: rdN high, wrN low reads
// - Fly-by: rdN low, wrN high writes
// - Fly-by controller uses memory-side strobe pairing
// - Requests update on active strobe falling edge
// - Acknowledge selects mailbox, no chip select
// - Bus style pin, fly-by control bit
`timescale 1ns/1ps
`include "dms_defs.svh"
module dms_device #(
    parameter int DEPTH = `DMS_DEPTH,
    parameter int AW = `DMS_ADDR_W
) (
    input wire logic mclk,
    input wire logic sys_rst,
    dms_if.dev bus,
    input wire logic flyBy,
    input wire logic sepStrobeMode,
    input wire logic txSpaceAvail,
    input wire logic [`DMS_DATA_W-1:0] rxWord,
    input wire logic rxWordValid,
    output logic rxWordTaken,
    output logic [`DMS_DATA_W-1:0] txWord,
    output logic txWordValid,
    input wire logic txWordTaken,
    output logic [AW:0] txFill
);
    typedef struct packed {
        logic [2:0] ackS;
        logic [2:0] rdS;
        logic [2:0] wrS;
        dms_pkg::dms_dir_t dir;
        dms_pkg::dms_state_t st;
        logic [`DMS_DATA_W-1:0] rdData;
        logic oe;
        logic txReq;
        logic rxReq;
        logic [AW-1:0] wPtr;
        logic [AW-1:0] rPtr;
        logic [AW:0] cnt;
        logic rxTake;
    } dms_dev_t;

    dms_dev_t s_reg, s_next;
    logic [`DMS_DATA_W-1:0] mem [DEPTH];
    logic memWe;
    logic rdFall, wrFall, rdRise, wrRise, ackOn;
    logic ackOff;
    logic decWrite, decRead;

    // synchronise and detect edges; bit 0 is first stage only
    assign ackOn = !s_reg.ackS[1];
    assign rdFall = s_reg.rdS[2] && !s_reg.rdS[1];
    assign wrFall = s_reg.wrS[2] && !s_reg.wrS[1];
    assign rdRise = !s_reg.rdS[2] && s_reg.rdS[1];
    assign wrRise = !s_reg.wrS[2] && s_reg.wrS[1];

    // Acknowledge withdrawn, from the synchronised copy
    assign ackOff = !s_reg.ackS[2] && s_reg.ackS[1];

    // Both strobes low decodes to nothing
    always_comb
    begin
        decWrite = 1'b0;
        decRead = 1'b0;
        if (sepStrobeMode && ackOn)
        begin
            if (flyBy)
            begin
                decRead = wrFall && s_reg.rdS[1];
                decWrite = rdFall && s_reg.wrS[1];
            end
            else
            begin
                decWrite = wrFall && s_reg.rdS[1];
                decRead = rdFall && s_reg.wrS[1];
            end
        end
    end

    always_comb
    begin
        logic strobeRise;
        logic doPush;
        logic doPop;
        strobeRise = 1'b0;
        doPush = 1'b0;
        doPop = 1'b0;
        s_next = s_reg;
        memWe = 1'b0;
        s_next.ackS = {s_reg.ackS[1:0], bus.dmaAckN};
        s_next.rdS = {s_reg.rdS[1:0], bus.rdN};
        s_next.wrS = {s_reg.wrS[1:0], bus.wrN};
        s_next.rxTake = 1'b0;
        doPop = txWordValid && txWordTaken;
        case (s_reg.st)
            dms_pkg::DMS_IDLE:
            begin
                if (decWrite)
                begin
                    s_next.dir = dms_pkg::DMS_DIR_WRITE;
                    s_next.st = dms_pkg::DMS_STROBE;
                    s_next.txReq = 1'b0;
                end
                else if (decRead)
                begin
                    s_next.dir = dms_pkg::DMS_DIR_READ;
                    s_next.st = dms_pkg::DMS_STROBE;
                    s_next.oe = 1'b1;
                    s_next.rdData = rxWord;
                    s_next.rxTake = rxWordValid;
                    s_next.rxReq = 1'b0;
                end
            end
            dms_pkg::DMS_STROBE:
            begin
                strobeRise = flyBy
                    ? (s_reg.dir == dms_pkg::DMS_DIR_WRITE ? rdRise : wrRise)
                    : (s_reg.dir == dms_pkg::DMS_DIR_WRITE ? wrRise : rdRise);
                if (strobeRise)
                begin
                    // capture on closing edge of active strobe
                    if (s_reg.dir == dms_pkg::DMS_DIR_WRITE &&
                        s_reg.cnt != (AW+1)'(DEPTH))
                    begin
                        memWe = 1'b1;
                        doPush = 1'b1;
                    end
                    s_next.oe = 1'b0;
                    s_next.st = dms_pkg::DMS_RECOVER;
                end
                else if (ackOff)
                begin
                    // acknowledge gone: drop the drive, store nothing
                    s_next.oe = 1'b0;
                    s_next.st = dms_pkg::DMS_RECOVER;
                end
            end
            dms_pkg::DMS_RECOVER:
            begin
                // Spacer cycle before the next decode
                s_next.dir = dms_pkg::DMS_DIR_NONE;
                s_next.st = dms_pkg::DMS_IDLE;
            end
            default:
            begin
                s_next.st = dms_pkg::DMS_IDLE;
                s_next.oe = 1'b0;
            end
        endcase
        // Push and pop in one cycle leave the fill unchanged
        if (doPush)
            s_next.wPtr = s_reg.wPtr + 1'b1;
        if (doPop)
            s_next.rPtr = s_reg.rPtr + 1'b1;
        if (doPush && !doPop)
            s_next.cnt = s_reg.cnt + 1'b1;
        else if (!doPush && doPop)
            s_next.cnt = s_reg.cnt - 1'b1;
        // Requests re-raised when idle and work remains
        if (s_reg.st == dms_pkg::DMS_IDLE && !decWrite && !decRead)
        begin
            s_next.txReq = txSpaceAvail && s_next.cnt != (AW+1)'(DEPTH);
            s_next.rxReq = rxWordValid;
        end
        if (sys_rst)
        begin
            s_next = '0;
            // Sync stages start at the idle pin level, no false edge
            s_next.ackS = 3'h7;
            s_next.rdS = 3'h7;
            s_next.wrS = 3'h7;
            s_next.st = dms_pkg::DMS_IDLE;
            s_next.dir = dms_pkg::DMS_DIR_NONE;
        end
    end

    always_ff @(posedge mclk)
    begin
        s_reg <= s_next;
        // Pins sampled late; data must outlast the sync latency
        if (memWe)
            mem[s_reg.wPtr] <= bus.dataToDev;
    end

    assign bus.dataFromDev = s_reg.rdData;
    // device drives data bus on read
    assign bus.dataFromDevOe = s_reg.oe;
    assign bus.dmaTxRequest = s_reg.txReq;
    assign bus.dmaRxRequest = s_reg.rxReq;
    assign rxWordTaken = s_reg.rxTake;
    // Buffer head shown before it is popped
    assign txWord = mem[s_reg.rPtr];
    assign txWordValid = s_reg.cnt != '0;
    assign txFill = s_reg.cnt;
endmodule : dms_device

// ### hw/dms_controller.sv
`timescale 1ns/1ps
`include "dms_defs.svh"
module dms_controller #(
    parameter int HOLD = `DMS_STROBE_MIN_CYC + 3
) (
    input wire logic mclk,
    input wire logic sys_rst,
    dms_if.ctl bus,
    input wire logic flyBy,
    input wire logic startWrite,
    input wire logic startRead,
    input wire logic [`DMS_DATA_W-1:0] wrData,
    output logic busy,
    output logic [`DMS_DATA_W-1:0] rdData,
    output logic rdValid
);
    typedef struct packed {
        dms_pkg::dms_state_t st;
        logic isRead;
        logic [7:0] cnt;
        logic ackN;
        logic rdN;
        logic wrN;
        logic [`DMS_DATA_W-1:0] wd;
        logic [`DMS_DATA_W-1:0] rd;
        logic rv;
    } dms_ctl_t;

    dms_ctl_t c_reg, c_next;

    always_comb
    begin
        c_next = c_reg;
        c_next.rv = 1'b0;
        case (c_reg.st)
            dms_pkg::DMS_IDLE:
            begin
                c_next.ackN = 1'b1;
                if ((startWrite && bus.dmaTxRequest) ||
                    (startRead && bus.dmaRxRequest))
                begin
                    c_next.isRead = !(startWrite && bus.dmaTxRequest);
                    c_next.wd = wrData;
                    c_next.ackN = 1'b0;
                    c_next.cnt = 8'h0;
                    c_next.st = dms_pkg::DMS_STROBE;
                end
            end
            dms_pkg::DMS_STROBE:
            begin
                c_next.cnt = c_reg.cnt + 8'h1;
                if (c_reg.cnt == 8'h1)
                begin
                    if (c_reg.isRead ^ flyBy)
                        c_next.rdN = 1'b0;
                    else
                        c_next.wrN = 1'b0;
                end
                if (c_reg.cnt == 8'(HOLD))
                begin
                    c_next.rd = bus.dataFromDev;
                    c_next.rv = c_reg.isRead;
                    c_next.rdN = 1'b1;
                    c_next.wrN = 1'b1;
                    c_next.cnt = 8'h0;
                    c_next.st = dms_pkg::DMS_RECOVER;
                end
            end
            dms_pkg::DMS_RECOVER:
            begin
                c_next.cnt = c_reg.cnt + 8'h1;
                if (c_reg.cnt == 8'(HOLD))
                begin
                    c_next.ackN = 1'b1;
                    c_next.st = dms_pkg::DMS_IDLE;
                end
            end
            default:
                c_next.st = dms_pkg::DMS_IDLE;
        endcase
        if (sys_rst)
        begin
            c_next = '0;
            c_next.st = dms_pkg::DMS_IDLE;
            c_next.ackN = 1'b1;
            c_next.rdN = 1'b1;
            c_next.wrN = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        c_reg <= c_next;
    end

    assign bus.dmaAckN = c_reg.ackN;
    assign bus.rdN = c_reg.rdN;
    assign bus.wrN = c_reg.wrN;
    assign bus.dataToDev = c_reg.wd;
    assign busy = c_reg.st != dms_pkg::DMS_IDLE;
    assign rdData = c_reg.rd;
    assign rdValid = c_reg.rv;
endmodule : dms_controller

// ### tb/dms_sva.sv
`timescale 1ns/1ps
module dms_sva (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic flyBy,
    input wire logic sepStrobeMode,
    input wire logic dmaAckN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic dataFromDevOe,
    input wire logic dmaTxRequest,
    input wire logic dmaRxRequest
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    property p_norm_write;
        $fell(wrN) && rdN && !dmaAckN && !flyBy |-> !dataFromDevOe [*6];
    endproperty
    a_norm_write: assert property (p_norm_write)
        else $error("data driven on normal write");

    property p_norm_read;
        $fell(rdN) && wrN && !dmaAckN && !flyBy |-> ##[2:5] dataFromDevOe;
    endproperty
    a_norm_read: assert property (p_norm_read)
        else $error("no drive on normal read");

    property p_fly_read;
        $fell(wrN) && rdN && !dmaAckN && flyBy |-> ##[2:5] dataFromDevOe;
    endproperty
    a_fly_read: assert property (p_fly_read)
        else $error("no drive on fly-by read");

    property p_fly_write;
        $fell(rdN) && wrN && !dmaAckN && flyBy |-> !dataFromDevOe [*6];
    endproperty
    a_fly_write: assert property (p_fly_write)
        else $error("data driven on fly-by write");

    property p_req_drop;
        !dmaAckN && sepStrobeMode && (flyBy ? $fell(rdN) && wrN
            : $fell(wrN) && rdN) |-> ##[2:5] !dmaTxRequest;
    endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("transmit request not withdrawn after strobe");

    property p_rx_drop;
        !dmaAckN && sepStrobeMode && (flyBy ? $fell(wrN) && rdN
            : $fell(rdN) && wrN) |-> ##[2:5] !dmaRxRequest;
    endproperty
    a_rx_drop: assert property (p_rx_drop)
        else $error("receive request not withdrawn after strobe");

    property p_ack_select;
        dataFromDevOe |-> !dmaAckN;
    endproperty
    a_ack_select: assert property (p_ack_select)
        else $error("data driven without acknowledge");

    property p_sync_delay;
        $fell(rdN) || $fell(wrN) |-> !dataFromDevOe [*2];
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("drive before strobe synchronised");

    property p_oe_release;
        ($rose(rdN) || $rose(wrN)) && dataFromDevOe
            |-> ##[1:5] !dataFromDevOe;
    endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("data bus held after strobe");
endmodule : dms_sva

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "dms_defs.svh"
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH %0t value differs", $time); end end
module tb_top;
    localparam int W = `DMS_DATA_W;
    logic mclk = 0;
    logic sys_rst = 1;
    logic flyBy = 0, sepStrobeMode = 1, txSpaceAvail = 1, rxWordValid = 0;
    logic txWordTaken = 0, startWrite = 0, startRead = 0;
    logic [W-1:0] wrData = '0, rxWord = '0, txWord, rdData, gotData;
    logic rxWordTaken, txWordValid, busy, rdValid, seenRd, seenWr, seenTake;
    logic [4:0] txFill;
    int miscompares = 0, nChecks = 0, cycles = 0;

    dms_if bus ();
    dms_device dms_device_i (.mclk(mclk), .sys_rst(sys_rst), .bus(bus),
        .flyBy(flyBy), .sepStrobeMode(sepStrobeMode),
        .txSpaceAvail(txSpaceAvail), .rxWord(rxWord),
        .rxWordValid(rxWordValid), .rxWordTaken(rxWordTaken),
        .txWord(txWord), .txWordValid(txWordValid),
        .txWordTaken(txWordTaken), .txFill(txFill));
    dms_controller dms_controller_i (.mclk(mclk), .sys_rst(sys_rst),
        .bus(bus), .flyBy(flyBy), .startWrite(startWrite),
        .startRead(startRead), .wrData(wrData), .busy(busy),
        .rdData(rdData), .rdValid(rdValid));
    dms_sva dms_sva_i (.mclk(mclk), .sys_rst(sys_rst), .flyBy(flyBy),
        .sepStrobeMode(sepStrobeMode),
        .dmaAckN(bus.dmaAckN), .rdN(bus.rdN), .wrN(bus.wrN),
        .dataFromDevOe(bus.dataFromDevOe), .dmaTxRequest(bus.dmaTxRequest),
        .dmaRxRequest(bus.dmaRxRequest));

    initial forever #10 mclk = ~mclk;

    task automatic finish_test;
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            finish_test();
        end
    end

    // One DMA access; records which strobes went low and any read word
    task automatic op(input logic fb, input logic rd, input logic [W-1:0] d);
        int i;
        flyBy <= fb;
        wrData <= d;
        rxWord <= d;
        rxWordValid <= rd;
        seenRd = 0;
        seenWr = 0;
        seenTake = 0;
        gotData = '0;
        i = 0;
        @(posedge mclk);
        startRead <= rd;
        startWrite <= !rd;
        while (!busy && i < 20)
        begin
            @(posedge mclk);
            i++;
        end
        startRead <= 0;
        startWrite <= 0;
        while (busy && i < 60)
        begin
            @(posedge mclk);
            i++;
            seenRd |= !bus.rdN;
            seenWr |= !bus.wrN;
            seenTake |= rxWordTaken;
            if (rdValid)
                gotData = rdData;
        end
        rxWordValid <= 0;
    endtask : op

    task automatic test_req;
        repeat (4) @(posedge mclk);
        `CHK(bus.dmaTxRequest, 1'b1)
        `CHK(bus.dmaRxRequest, 1'b0)
        txSpaceAvail <= 0;
        repeat (3) @(posedge mclk);
        `CHK(bus.dmaTxRequest, 1'b0)
        txSpaceAvail <= 1;
        repeat (3) @(posedge mclk);
        `CHK(bus.dmaTxRequest, 1'b1)
        $display("test_req done");
    endtask : test_req

    task automatic test_write;
        op(1'b0, 1'b0, 16'ha5c3);
        `CHK({seenWr, seenRd}, 2'b10)
        `CHK(seenTake, 1'b0)
        `CHK(txFill, 5'h01)
        op(1'b1, 1'b0, 16'h3c5a);
        `CHK({seenWr, seenRd}, 2'b01)
        `CHK(txFill, 5'h02)
        `CHK(txWordValid, 1'b1)
        `CHK(txWord, 16'ha5c3)
        txWordTaken <= 1;
        @(posedge mclk);
        txWordTaken <= 0;
        repeat (2) @(posedge mclk);
        `CHK(txWord, 16'h3c5a)
        `CHK(txFill, 5'h01)
        $display("test_write done");
    endtask : test_write

    task automatic test_read;
        op(1'b0, 1'b1, 16'h1234);
        `CHK({seenWr, seenRd}, 2'b01)
        `CHK(gotData, 16'h1234)
        `CHK(seenTake, 1'b1)
        op(1'b1, 1'b1, 16'hbeef);
        `CHK({seenWr, seenRd}, 2'b10)
        `CHK(gotData, 16'hbeef)
        $display("test_read done");
    endtask : test_read

    task automatic test_mode;
        sepStrobeMode <= 0;
        op(1'b0, 1'b0, 16'h0f0f);
        `CHK({seenWr, seenRd}, 2'b10)
        `CHK(txFill, 5'h01)
        `CHK(txWord, 16'h3c5a)
        `CHK(bus.dmaTxRequest, 1'b1)
        sepStrobeMode <= 1;
        $display("test_mode done");
    endtask : test_mode

    initial
    begin
        repeat (12) @(posedge mclk);
        sys_rst <= 0;
        test_req();
        test_write();
        test_read();
        test_mode();
        finish_test();
    end
endmodule : tb_top
